//--- src/arsq_seq.sv
// Cell-and-stack conversion sequencer with digital redundancy checking.
//
// Decided for this implementation: the address map and strobed register access.
module arsq_seq #(
  parameter int US_CYCLES = arsq_pkg::CYC_PER_US
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [15:0] reg_rdata,
  input  wire logic        mod_bit,
  output logic             busy,
  output logic             conv_done
);

  localparam int SKEW_FAST_CYC = arsq_pkg::SKEW_FAST_US * US_CYCLES;
  localparam int T7M_FAST_CYC  = arsq_pkg::T7M_US[0] * US_CYCLES;
  localparam int TC_FAST_CYC   = arsq_pkg::TC_US[0] * US_CYCLES;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state.

  arsq_pkg::arsq_cfg_type   cfg_q;
  arsq_pkg::arsq_cfg_type   run_cfg_q;
  arsq_pkg::arsq_cmd_type   cmd_q;
  arsq_pkg::arsq_state_type state_q;
  logic [31:0]              run_q;
  logic [2:0]               sub_q;
  logic                     mod_meta_q;
  logic                     mod_sync_q;
  logic [15:0]              res_q [arsq_pkg::RES_WORDS];
  logic [15:0]              rdata_q;
  logic                     busy_q;
  logic                     done_q;

  logic                     start;
  logic                     hit;
  logic                     store;
  logic                     last_sub;
  logic [31:0]              tgt;
  logic [2:0]               n_half;
  logic                     cell_cmd;
  logic                     s_dual;
  arsq_pkg::arsq_kind_type  kind;
  logic [2:0]               cell_idx;
  logic [3:0]               res_idx;
  logic                     chk_en;
  logic [15:0]              pri_val;
  logic [15:0]              red_val;
  logic [15:0]              chk_word;
  logic                     chk_fault;
  logic [15:0]              store_word;

  ////////////////////////////////////////////////////////////////////////////
  // Modulator input synchroniser.

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mod_meta_q <= 1'b0;
      mod_sync_q <= 1'b0;
    end else if (ce) begin
      mod_meta_q <= mod_bit;
      mod_sync_q <= mod_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  // A command write is taken only while idle; a write during a run is
  // dropped so a running sequence can never be restarted half way.
  assign start = reg_we && (reg_addr == arsq_pkg::ADDR_CMD) && (state_q == arsq_pkg::ST_IDLE);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= arsq_pkg::CFG_RST;
    end else if (ce && reg_we && (reg_addr == arsq_pkg::ADDR_CFG)) begin
      cfg_q <= arsq_pkg::arsq_cfg_type'(reg_wdata[5:0]);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else if (ce) begin
      rdata_q <= 16'h0000;
      if (reg_re) begin
        if (reg_addr == arsq_pkg::ADDR_CFG) begin
          rdata_q <= {10'h000, cfg_q};
        end else if (reg_addr == arsq_pkg::ADDR_CMD) begin
          rdata_q <= {busy_q, 9'h000, state_q, sub_q};
        end else if (reg_addr <= arsq_pkg::ADDR_STACK) begin
          rdata_q <= res_q[reg_addr - arsq_pkg::ADDR_CELL0];
        end
      end
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Timeline targets, in cycles from the start of the run.

  assign cell_cmd = (cmd_q == arsq_pkg::CMD_CELL_STACK) || (cmd_q == arsq_pkg::CMD_CELL);
  assign s_dual   = run_cfg_q.s_pin_en && cell_cmd;
  assign n_half   = s_dual ? 3'd6 : 3'd3;
  assign last_sub = (sub_q == (n_half - 3'd1));

  always_comb begin
    int t3;
    int t4;
    int t7;
    int tc;
    int meas_end;
    t3 = arsq_pkg::T3M_US[run_cfg_q.mode] * US_CYCLES;
    t4 = arsq_pkg::T4M_US[run_cfg_q.mode] * US_CYCLES;
    t7 = arsq_pkg::T7M_US[run_cfg_q.mode] * US_CYCLES;
    tc = arsq_pkg::TC_US[run_cfg_q.mode] * US_CYCLES;
    meas_end = cell_cmd ? t7 : (t4 - t3);
    unique case (state_q)
      arsq_pkg::ST_PRE:  tgt = 32'((t3 * (int'(sub_q) + 1)) / int'(n_half));
      arsq_pkg::ST_SC:   tgt = cell_cmd ? 32'(t4) : 32'(t4 - t3);
      arsq_pkg::ST_POST: tgt = 32'(t4 + ((t7 - t4) * (int'(sub_q) + 1)) / int'(n_half));
      arsq_pkg::ST_CAL:  tgt = 32'(meas_end
                             + ((tc - t7) * (int'(sub_q) + 1)) / arsq_pkg::CAL_STEPS);
      default:           tgt = 32'h0000_0001;
    endcase
  end

  assign hit = ce && (state_q != arsq_pkg::ST_IDLE) && (run_q == (tgt - 32'd1));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. Cells 1-3 run before the stack sum and cells 4-6 after it,
  // which puts the stack sum near the middle and bounds the skew.

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q   <= arsq_pkg::ST_IDLE;
      sub_q     <= 3'd0;
      run_q     <= 32'd0;
      cmd_q     <= arsq_pkg::CMD_CELL_STACK;
      run_cfg_q <= arsq_pkg::CFG_RST;
    end else if (ce) begin
      if (state_q != arsq_pkg::ST_IDLE) begin
        run_q <= run_q + 32'd1;
      end
      unique case (state_q)
        arsq_pkg::ST_IDLE: begin
          if (start) begin
            cmd_q     <= arsq_pkg::arsq_cmd_type'(reg_wdata[1:0]);
            run_cfg_q <= cfg_q;
            run_q     <= 32'd0;
            sub_q     <= 3'd0;
            state_q   <= reg_wdata[1] ? arsq_pkg::ST_SC : arsq_pkg::ST_PRE;
          end
        end
        arsq_pkg::ST_PRE: begin
          if (hit) begin
            sub_q   <= last_sub ? 3'd0 : sub_q + 3'd1;
            state_q <= last_sub ? arsq_pkg::ST_SC : arsq_pkg::ST_PRE;
          end
        end
        arsq_pkg::ST_SC: begin
          if (hit) begin
            state_q <= cell_cmd ? arsq_pkg::ST_POST : arsq_pkg::ST_CAL;
          end
        end
        arsq_pkg::ST_POST: begin
          if (hit) begin
            sub_q   <= last_sub ? 3'd0 : sub_q + 3'd1;
            state_q <= last_sub ? arsq_pkg::ST_CAL : arsq_pkg::ST_POST;
          end
        end
        arsq_pkg::ST_CAL: begin
          // The calibration count does not depend on any setting.
          if (hit) begin
            sub_q   <= (sub_q == 3'(arsq_pkg::CAL_STEPS - 1)) ? 3'd0 : sub_q + 3'd1;
            state_q <= (sub_q == 3'(arsq_pkg::CAL_STEPS - 1)) ? arsq_pkg::ST_IDLE
                                                               : arsq_pkg::ST_CAL;
          end
        end
        default: begin
          state_q <= arsq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= (state_q == arsq_pkg::ST_CAL) && hit
                && (sub_q == 3'(arsq_pkg::CAL_STEPS - 1));
      if (start) begin
        busy_q <= 1'b1;
      end else if (state_q == arsq_pkg::ST_CAL && hit
                   && sub_q == 3'(arsq_pkg::CAL_STEPS - 1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign busy      = busy_q;
  assign conv_done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Slot decoding and result routing.

  always_comb begin
    kind     = arsq_pkg::KIND_C;
    cell_idx = 3'd0;
    if (state_q == arsq_pkg::ST_SC) begin
      kind = arsq_pkg::KIND_STACK;
    end else begin
      cell_idx = (state_q == arsq_pkg::ST_POST) ? 3'(arsq_pkg::HALF_CELLS) : 3'd0;
      if (s_dual) begin
        kind     = sub_q[0] ? arsq_pkg::KIND_S : arsq_pkg::KIND_C;
        cell_idx = cell_idx + {1'b0, sub_q[2:1]};
      end else begin
        cell_idx = cell_idx + sub_q;
      end
    end
  end

  always_comb begin
    unique case (kind)
      arsq_pkg::KIND_S:     res_idx = 4'(arsq_pkg::RES_SPIN0) + {1'b0, cell_idx};
      arsq_pkg::KIND_STACK: res_idx = 4'(arsq_pkg::RES_STACK);
      default:              res_idx = {1'b0, cell_idx};
    endcase
  end

  // The plain cell command spends the stack slot's time but keeps no result.
  assign store = hit && (state_q inside {arsq_pkg::ST_PRE, arsq_pkg::ST_SC, arsq_pkg::ST_POST})
                 && !(state_q == arsq_pkg::ST_SC && cmd_q == arsq_pkg::CMD_CELL);

  // S-pin runs borrow the redundant filter as the measurement path, so
  // cell checking is off whenever the S-pin bit is set.
  assign chk_en = (cmd_q != arsq_pkg::CMD_STAT) && !run_cfg_q.red_dis
                  && ((kind == arsq_pkg::KIND_STACK) || !run_cfg_q.s_pin_en);

  ////////////////////////////////////////////////////////////////////////////
  // Filters and comparison; both filters see the same synchronised bit.

  arsq_filter #(.W(16)) u_primary (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .clear   (start || store),
    .bit_in  (mod_sync_q),
    .value   (pri_val)
  );

  arsq_filter #(.W(16)) u_redundant (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .clear   (start || store),
    .bit_in  (mod_sync_q),
    .value   (red_val)
  );

  arsq_redcheck u_check (
    .enable     (chk_en),
    .force_fail (run_cfg_q.force_fail),
    .primary    (pri_val),
    .redundant  (red_val),
    .word       (chk_word),
    .fault      (chk_fault)
  );

  assign store_word = (kind == arsq_pkg::KIND_S) ? red_val
                    : (chk_en ? chk_word : pri_val);

  for (genvar r = 0; r < arsq_pkg::RES_WORDS; r++) begin : g_res
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        res_q[r] <= arsq_pkg::RESULT_RST;
      end else if (store && (res_idx == 4'(r))) begin
        res_q[r] <= store_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks and their helper counters.

  logic [3:0]  store_cnt_q;
  logic [31:0] sc_time_q;
  logic [2:0]  cal_cnt_q;
  logic        fast_plain;

  assign fast_plain = (cmd_q == arsq_pkg::CMD_CELL_STACK) && (run_cfg_q.mode == 3'h0)
                      && !run_cfg_q.s_pin_en;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      store_cnt_q <= 4'd0;
      sc_time_q   <= 32'd0;
      cal_cnt_q   <= 3'd0;
    end else if (ce) begin
      if (start) begin
        store_cnt_q <= 4'd0;
        cal_cnt_q   <= 3'd0;
      end else begin
        if (store) begin
          store_cnt_q <= store_cnt_q + 4'd1;
        end
        if (hit && state_q == arsq_pkg::ST_CAL) begin
          cal_cnt_q <= cal_cnt_q + 3'd1;
        end
      end
      if (store && kind == arsq_pkg::KIND_STACK) begin
        sc_time_q <= run_q;
      end
    end
  end

  chk_fault_nibble: assert property (@(posedge clk_sys) disable iff (!nrst)
    (store && chk_fault) |-> (store_word[3:0] != 4'h0) && (store_word[15:4] == 12'hff0))
    else $error("fault word has empty nibble field");

  chk_result_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    (store && !chk_fault) |-> (store_word <= 16'hdfff))
    else $error("plain result above valid range");

  chk_force_fail: assert property (@(posedge clk_sys) disable iff (!nrst)
    (store && chk_en && run_cfg_q.force_fail) |=> (res_q[$past(res_idx)][15:4] == 12'hff0))
    else $error("forced failure not stored as fault word");

  chk_dis_plain: assert property (@(posedge clk_sys) disable iff (!nrst)
    (store && run_cfg_q.red_dis && kind != arsq_pkg::KIND_S) |-> (store_word == pri_val))
    else $error("disabled check did not store primary result");

  chk_spin_source: assert property (@(posedge clk_sys) disable iff (!nrst)
    (store && kind == arsq_pkg::KIND_S) |-> (store_word == red_val) && !chk_en)
    else $error("S-pin result not taken unchecked from redundant filter");

  chk_seven_meas: assert property (@(posedge clk_sys) disable iff (!nrst)
    (store && state_q == arsq_pkg::ST_POST && last_sub && fast_plain)
      |-> (store_cnt_q == 4'd6) && (sc_time_q != 32'd0))
    else $error("combined command did not take seven measurements");

  chk_skew_fast: assert property (@(posedge clk_sys) disable iff (!nrst)
    (store && state_q == arsq_pkg::ST_POST && fast_plain)
      |-> ((run_q - sc_time_q) <= 32'(SKEW_FAST_CYC)))
    else $error("cell to stack skew too large in fast mode");

  chk_seventh_time: assert property (@(posedge clk_sys) disable iff (!nrst)
    (store && store_cnt_q == 4'd6 && fast_plain) |-> (run_q == 32'(T7M_FAST_CYC - 1)))
    else $error("seventh measurement not at its fast mode time");

  chk_total_time: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($fell(busy_q) && fast_plain) |-> (run_q == 32'(TC_FAST_CYC)) && (cal_cnt_q == 3'd7)
      && conv_done)
    else $error("command end time or calibration count wrong");

endmodule // arsq_seq

//--- src/arsq_pkg.sv
// Shared constants, tables and types for the redundancy conversion sequencer.
package arsq_pkg;

  // Clock rate: cycles per microsecond at 250 MHz.
  localparam int CLK_PERIOD_NS = 4;
  localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;

  // Per-mode times in microseconds, mode 0 is the fast (27 kHz) mode.
  localparam int T3M_US [8] = '{151, 238, 413, 762, 1460, 2856, 5649, 89431};
  localparam int T4M_US [8] = '{205, 321, 554, 1019, 1950, 3812, 7536, 119245};
  localparam int T7M_US [8] = '{352, 556, 963, 1777, 3407, 6665, 13181, 208672};
  localparam int TC_US  [8] = '{1316, 1520, 2742, 3556, 5185, 8443, 14960, 234887};
  localparam int SKEW_FAST_US = 147;

  // Sequence shape.
  localparam int NUM_CELLS  = 6;
  localparam int CAL_STEPS  = 7;
  localparam int HALF_CELLS = 3;

  // Register word offsets.
  localparam logic [3:0] ADDR_CFG   = 4'h0;
  localparam logic [3:0] ADDR_CMD   = 4'h1;
  localparam logic [3:0] ADDR_CELL0 = 4'h2;
  localparam logic [3:0] ADDR_SPIN0 = 4'h8;
  localparam logic [3:0] ADDR_STACK = 4'he;

  // Result index layout inside the result array.
  localparam int RES_SPIN0 = 6;
  localparam int RES_STACK = 12;
  localparam int RES_WORDS = 13;

  // Result values.
  localparam logic [15:0] RESULT_MAX = 16'hdfff;
  localparam logic [15:0] RESULT_RST = 16'hffff;
  localparam logic [11:0] FAULT_HI   = 12'hff0;
  localparam logic [3:0]  FORCE_MASK = 4'hf;

  typedef struct packed {
    logic       force_fail;
    logic       s_pin_en;
    logic       red_dis;
    logic [2:0] mode;
  } arsq_cfg_type;

  localparam arsq_cfg_type CFG_RST = '{force_fail: 1'b0, s_pin_en: 1'b0, red_dis: 1'b0,
                                       mode: 3'h0};

  typedef enum logic [1:0] {
    CMD_CELL_STACK = 2'b00,
    CMD_CELL       = 2'b01,
    CMD_STAT       = 2'b10,
    CMD_STATD      = 2'b11
  } arsq_cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE  = 3'b001,
    ST_SC   = 3'b010,
    ST_POST = 3'b011,
    ST_CAL  = 3'b100
  } arsq_state_type;

  typedef enum logic [1:0] {
    KIND_C     = 2'b00,
    KIND_S     = 2'b01,
    KIND_STACK = 2'b10
  } arsq_kind_type;

endpackage

//--- src/arsq_filter.sv
// Counting decimation filter fed by the modulator bit stream.
module arsq_filter #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         clear,
  input  wire logic         bit_in,
  output logic      [W-1:0] value
);

  // Saturation keeps every real result below the fault code range.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      value <= '0;
    end else if (ce) begin
      if (clear) begin
        value <= '0;
      end else if (bit_in && (value < W'(arsq_pkg::RESULT_MAX))) begin
        value <= value + W'(1);
      end
    end
  end

endmodule // arsq_filter

//--- src/arsq_redcheck.sv
// Compares primary and redundant filter outputs and builds the fault word.
module arsq_redcheck (
  input  wire logic        enable,
  input  wire logic        force_fail,
  input  wire logic [15:0] primary,
  input  wire logic [15:0] redundant,
  output logic      [15:0] word,
  output logic             fault
);

  logic [3:0] mask_raw;
  logic [3:0] mask;

  for (genvar g = 0; g < 4; g++) begin : g_nib
    assign mask_raw[g] = |(primary[4*g+3:4*g] ^ redundant[4*g+3:4*g]);
  end

  // A forced failure with matching filters flags all nibbles, so the
  // low field is never left at zero.
  assign mask  = (force_fail && (mask_raw == 4'h0)) ? arsq_pkg::FORCE_MASK : mask_raw;
  assign fault = enable && (mask != 4'h0);
  assign word  = fault ? {arsq_pkg::FAULT_HI, mask} : primary;

endmodule // arsq_redcheck

//--- dv/arsq_host_model.sv
// Host controller model that drives the register port of the sequencer.
module arsq_host_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        conv_done,
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_we,
  output logic             reg_re
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PAIR_TOL = 4;

  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse of the last value, so stale contents never help.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask

  // Polls three words round robin each cycle; times count from the edge taking the command.
  task automatic convert(input logic [1:0] cmd, input logic [3:0] pa [3],
                         output int t_done, output int t_seen [3]);
    t_done = -1;
    t_seen = '{-1, -1, -1};
    wr(arsq_pkg::ADDR_CMD, {14'h0000, cmd});
    for (int n = 1; n < 300000 && t_done < 0; n++) begin
      @(posedge clk_sys);
      reg_re   <= 1'b1;
      reg_addr <= pa[n % 3];
      #1;
      if (conv_done === 1'b1) t_done = n;
      if (n > 1 && t_seen[(n + 2) % 3] < 0 && reg_rdata !== 16'hffff) t_seen[(n + 2) % 3] = n;
    end
    @(posedge clk_sys);
    reg_re <= 1'b0;
  endtask

  // C and S are counted over adjacent slots that can differ in length, so a few codes of difference are normal.
  function automatic logic pair_ok(input logic [15:0] c, input logic [15:0] s);
    return ((c > s) ? c - s : s - c) <= 16'(PAIR_TOL);
  endfunction
endmodule // arsq_host_model

//--- dv/arsq_seq_tb.sv
// Self-checking bench for the redundancy conversion sequencer.
module arsq_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_sys;
  logic                  nrst;
  logic                  mod_bit;
  logic [3:0]            reg_addr;
  logic [15:0]           reg_wdata;
  logic                  reg_we;
  logic                  reg_re;
  logic [15:0]           reg_rdata;
  logic                  busy;
  logic                  conv_done;
  logic [15:0]           rv;
  logic [15:0]           sv;
  arsq_pkg::arsq_cfg_type cfg;
  int                    n_errors;
  int                    checks_done;
  int                    t_done;
  int                    t_seen [3];

  arsq_seq #(.US_CYCLES(1)) i_arsq_seq (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ce       (1'b1),
    .reg_addr (reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we   (reg_we),
    .reg_re   (reg_re),
    .reg_rdata(reg_rdata),
    .mod_bit  (mod_bit),
    .busy     (busy),
    .conv_done(conv_done)
  );

  arsq_host_model i_arsq_host_model (
    .clk_sys  (clk_sys),
    .reg_rdata(reg_rdata),
    .conv_done(conv_done),
    .reg_addr (reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we   (reg_we),
    .reg_re   (reg_re)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_in(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask

  task automatic rd(input logic [3:0] a);
    i_arsq_host_model.rd(a, rv);
  endtask

  // Config is read back at once so a lost write shows up before the conversion.
  task automatic set_cfg(input logic f, input logic s, input logic d, input logic [2:0] m);
    cfg = '{force_fail: f, s_pin_en: s, red_dis: d, mode: m};
    i_arsq_host_model.wr(arsq_pkg::ADDR_CFG, {10'h000, cfg});
    rd(arsq_pkg::ADDR_CFG);
    chk16("config", {10'h000, cfg}, rv);
  endtask

  task automatic run(input arsq_pkg::arsq_cmd_type c);
    i_arsq_host_model.convert(c, '{arsq_pkg::ADDR_CELL0, arsq_pkg::ADDR_STACK,
                                   arsq_pkg::ADDR_CELL0 + 4'h5}, t_done, t_seen);
  endtask

  task automatic words(input logic [3:0] a0, input logic [15:0] exp,
                       input int cnt = arsq_pkg::NUM_CELLS);
    for (int i = 0; i < cnt; i++) begin
      rd(a0 + 4'(i));
      chk16("result word", exp, rv);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic sc_timing();
    set_cfg(1'b0, 1'b0, 1'b0, 3'h0);
    run(arsq_pkg::CMD_CELL_STACK);
    chk_in("done cycle", arsq_pkg::TC_US[0], arsq_pkg::TC_US[0], t_done);
    chk16("busy after end", 16'h0000, {15'h0, busy});
    chk_in("seventh store", arsq_pkg::T7M_US[0], arsq_pkg::T7M_US[0] + 5, t_seen[2]);
    chk_in("stack skew", 0, arsq_pkg::SKEW_FAST_US + 3, t_seen[2] - t_seen[1]);
    chk_in("stack order", t_seen[0] + 1, t_seen[2] - 1, t_seen[1]);
    words(arsq_pkg::ADDR_CELL0, 16'h0000);
    words(arsq_pkg::ADDR_STACK, 16'h0000, 1);
    words(arsq_pkg::ADDR_SPIN0, arsq_pkg::RESULT_RST);
  endtask

  task automatic sc_force();
    set_cfg(1'b1, 1'b0, 1'b0, 3'h0);
    run(arsq_pkg::CMD_CELL_STACK);
    words(arsq_pkg::ADDR_CELL0, 16'hff0f);
    words(arsq_pkg::ADDR_STACK, 16'hff0f, 1);
    set_cfg(1'b1, 1'b0, 1'b1, 3'h0);
    run(arsq_pkg::CMD_CELL_STACK);
    words(arsq_pkg::ADDR_CELL0, 16'h0000);
    words(arsq_pkg::ADDR_STACK, 16'h0000, 1);
  endtask

  task automatic sc_spin();
    do_reset();
    set_cfg(1'b1, 1'b1, 1'b0, 3'h0);
    run(arsq_pkg::CMD_CELL_STACK);
    chk_in("done cycle", arsq_pkg::TC_US[0], arsq_pkg::TC_US[0], t_done);
    words(arsq_pkg::ADDR_CELL0, 16'h0000);
    words(arsq_pkg::ADDR_SPIN0, 16'h0000);
    words(arsq_pkg::ADDR_STACK, 16'hff0f, 1);
    mod_bit <= 1'b1;
    set_cfg(1'b0, 1'b1, 1'b0, 3'h0);
    run(arsq_pkg::CMD_CELL_STACK);
    for (int i = 0; i < arsq_pkg::NUM_CELLS; i++) begin
      rd(arsq_pkg::ADDR_CELL0 + 4'(i));
      sv = rv;
      rd(arsq_pkg::ADDR_SPIN0 + 4'(i));
      chk16("cell in range", 16'h0001, {15'h0, sv != 0 && sv <= arsq_pkg::RESULT_MAX});
      chk16("c and s agree", 16'h0001, {15'h0, i_arsq_host_model.pair_ok(sv, rv)});
    end
    mod_bit <= 1'b0;
  endtask

  task automatic sc_cmds();
    set_cfg(1'b1, 1'b0, 1'b0, 3'h0);
    run(arsq_pkg::CMD_STAT);
    words(arsq_pkg::ADDR_STACK, 16'h0000, 1);
    run(arsq_pkg::CMD_STATD);
    words(arsq_pkg::ADDR_STACK, 16'hff0f, 1);
    run(arsq_pkg::CMD_CELL);
    words(arsq_pkg::ADDR_CELL0, 16'hff0f);
  endtask

  task automatic sc_modes();
    mod_bit <= 1'b1;
    for (int m = 1; m < 3; m++) begin
      set_cfg(1'b0, 1'b0, 1'b0, 3'(m));
      run(arsq_pkg::CMD_CELL_STACK);
      chk_in("done cycle", arsq_pkg::TC_US[m], arsq_pkg::TC_US[m], t_done);
    end
    rd(arsq_pkg::ADDR_CELL0);
    chk16("checked in range", 16'h0001, {15'h0, rv != 0 && rv <= arsq_pkg::RESULT_MAX});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    $display("mismatch watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial begin
    nrst        = 1'b0;
    mod_bit     = 1'b0;
    n_errors    = 0;
    checks_done = 0;
    do_reset();
    rd(arsq_pkg::ADDR_CFG);
    chk16("config after reset", 16'h0000, rv);
    rd(arsq_pkg::ADDR_CMD);
    chk16("status after reset", 16'h0000, rv);
    rd(4'hf);
    chk16("unmapped read", 16'h0000, rv);
    sc_timing();
    sc_force();
    sc_spin();
    sc_cmds();
    sc_modes();
    tally_and_finish();
  end
endmodule // arsq_seq_tb
